// ### hw/rmt_pkg.sv
// Operation
// - clock_rate_select 00/01/10/11 divides oscillator by 32768, 8, 4, 1; coarse_trim_enable set divides by 512 instead.
// - trimming shifts every rate except undivided 11, which bypasses trim.
// - no square wave on the pin while on backup supply.
// - alarm output needs an enabled alarm and square wave off; square wave wins.
// - alarm output keeps working on backup supply.
// - single alarm: pin follows flag if polarity 1, inverse if 0.
// - both alarms: OR of flags if polarity 1, NAND if polarity 0.
// - all modes off: pin follows gp_level.
// - general-purpose level not driven while on backup supply.
// - coarse_trim_enable clear: trim applied once per minute.
// - trim_direction selects adding or removing oscillator cycles.
// - each trim_magnitude unit moves two oscillator pulses per adjustment.
// - trim_magnitude zero disables trimming entirely.
// - trimming continues on backup supply.
// - coarse_trim_enable set: trim applied 128 times per second.
// - pin only pulled low or released; board pull-up makes the high.
package rmt_pkg;
	localparam logic [7:0] RMT_CTRL_ADDR = 8'h07;
	localparam logic [7:0] RMT_TRIM_ADDR = 8'h08;
	localparam logic [7:0] RMT_CTRL_RST = 8'h80;
	localparam logic [7:0] RMT_TRIM_RST = 8'h00;
	localparam int RMT_GP_LEVEL_BIT = 7;
	localparam int RMT_CLK_EN_BIT = 6;
	localparam int RMT_ALM1_EN_BIT = 5;
	localparam int RMT_ALM0_EN_BIT = 4;
	localparam int RMT_COARSE_BIT = 2;
	localparam int RMT_RATE_HI = 1;
	localparam int RMT_RATE_LO = 0;
	localparam int RMT_DIR_BIT = 7;
	localparam int RMT_MAG_HI = 6;
	localparam int RMT_PRESC_W = 15;
	localparam logic [14:0] RMT_PRESC_LAST = 15'h7FFF;
	localparam logic [7:0] RMT_COARSE_LAST = 8'hFF;
	localparam logic [5:0] RMT_SEC_LAST = 6'h3B;
	localparam int RMT_TAP_1HZ = 14;
	localparam int RMT_TAP_DIV8 = 2;
	localparam int RMT_TAP_DIV4 = 1;
	localparam int RMT_TAP_64HZ = 8;
	localparam logic [1:0] RMT_RATE_1HZ = 2'h0;
	localparam logic [1:0] RMT_RATE_DIV8 = 2'h1;
	localparam logic [1:0] RMT_RATE_DIV4 = 2'h2;
	localparam logic [1:0] RMT_RATE_DIV1 = 2'h3;
	typedef enum logic [1:0] {
		RMT_MODE_GP = 2'b00,
		RMT_MODE_ALARM = 2'b01,
		RMT_MODE_SQW = 2'b10,
		RMT_MODE_OFF = 2'b11
	} rmt_mode_e;
endpackage

// ### hw/rmt_top.sv
`timescale 1ns/10ps
module rmt_top
	import rmt_pkg::*;
(
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic osc_level_i,
	input wire logic backup_mode_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic alarm_polarity_i,
	input wire logic alarm0_flag_i,
	input wire logic alarm1_flag_i,
	output logic multi_function_pin_o,
	output logic multi_function_pin_oe_n_o,
	output logic trim_tick_o
);
	logic [7:0] ctrl_r;
	logic [7:0] trim_r;
	logic osc_q_r;
	logic [7:0] trim_pend_r;
	logic trim_add_r;
	logic [RMT_PRESC_W-1:0] presc_r;
	logic [5:0] sec_cnt_r;
	logic pin_level_r;
	logic pin_level_nxt;
	logic osc_tick;
	logic remove_act;
	logic add_act;
	logic eff_tick;
	logic sec_wrap;
	logic coarse_wrap;
	logic minute_wrap;
	logic trim_evt;
	logic sqw_level;
	logic gp_level;
	logic clock_out_enable;
	logic alarm0_enable;
	logic alarm1_enable;
	logic coarse_trim_enable;
	logic [1:0] clock_rate_select;
	logic trim_direction;
	logic [6:0] trim_magnitude;
	rmt_mode_e mode;

	assign gp_level = ctrl_r[RMT_GP_LEVEL_BIT];
	assign clock_out_enable = ctrl_r[RMT_CLK_EN_BIT];
	assign alarm1_enable = ctrl_r[RMT_ALM1_EN_BIT];
	assign alarm0_enable = ctrl_r[RMT_ALM0_EN_BIT];
	assign coarse_trim_enable = ctrl_r[RMT_COARSE_BIT];
	assign clock_rate_select = ctrl_r[RMT_RATE_HI:RMT_RATE_LO];
	assign trim_direction = trim_r[RMT_DIR_BIT];
	assign trim_magnitude = trim_r[RMT_MAG_HI:0];

	// register writes
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_r <= RMT_CTRL_RST;
			trim_r <= RMT_TRIM_RST;
		end
		else if (reg_wr_i)
		begin
			if (reg_addr_i == RMT_CTRL_ADDR)
				ctrl_r <= reg_wdata_i;
			else if (reg_addr_i == RMT_TRIM_ADDR)
				trim_r <= reg_wdata_i;
		end
	end

	// readback; unmapped addresses read zero
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			reg_rdata_o <= 8'h00;
		else if (reg_addr_i == RMT_CTRL_ADDR)
			reg_rdata_o <= ctrl_r;
		else if (reg_addr_i == RMT_TRIM_ADDR)
			reg_rdata_o <= trim_r;
		else
			reg_rdata_o <= 8'h00;
	end

	// oscillator edge; its level is taken as synchronous
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			osc_q_r <= 1'b0;
		else
			osc_q_r <= osc_level_i;
	end

	assign osc_tick = osc_level_i & ~osc_q_r;
	assign remove_act = ~trim_add_r & (trim_pend_r != 8'h00);
	assign add_act = trim_add_r & (trim_pend_r != 8'h00);
	// added pulses go into idle system cycles, so they never merge with real
	// oscillator edges; 20 MHz leaves ample room even for 254 of them
	assign eff_tick = (osc_tick & ~remove_act) | (add_act & ~osc_tick);

	// trim engine runs regardless of supply state
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			trim_pend_r <= 8'h00;
			trim_add_r <= 1'b0;
		end
		else if (trim_evt)
		begin
			trim_pend_r <= {trim_magnitude, 1'b0};
			trim_add_r <= trim_direction;
		end
		else if ((remove_act & osc_tick) | (add_act & ~osc_tick))
			trim_pend_r <= trim_pend_r - 8'h01;
	end

	// postscaler on the trimmed tick stream
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			presc_r <= '0;
		else if (eff_tick)
			presc_r <= presc_r + 15'h0001;
	end

	assign sec_wrap = eff_tick & (presc_r == RMT_PRESC_LAST);
	assign coarse_wrap = eff_tick & (presc_r[7:0] == RMT_COARSE_LAST);
	assign minute_wrap = sec_wrap & (sec_cnt_r == RMT_SEC_LAST);
	assign trim_evt = coarse_trim_enable ? coarse_wrap : minute_wrap;

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			sec_cnt_r <= 6'h00;
		else if (minute_wrap)
			sec_cnt_r <= 6'h00;
		else if (sec_wrap)
			sec_cnt_r <= sec_cnt_r + 6'h01;
	end

	// postscaler taps are counter bits, hence 50% duty
	always_comb
	begin
		if (coarse_trim_enable)
			sqw_level = presc_r[RMT_TAP_64HZ];
		else if (clock_rate_select == RMT_RATE_1HZ)
			sqw_level = presc_r[RMT_TAP_1HZ];
		else if (clock_rate_select == RMT_RATE_DIV8)
			sqw_level = presc_r[RMT_TAP_DIV8];
		else if (clock_rate_select == RMT_RATE_DIV4)
			sqw_level = presc_r[RMT_TAP_DIV4];
		else
			sqw_level = osc_level_i; // untrimmed bypass
	end

	// square wave first, then alarms, then general purpose
	always_comb
	begin
		if (clock_out_enable)
			mode = backup_mode_i ? RMT_MODE_OFF : RMT_MODE_SQW;
		else if (alarm0_enable | alarm1_enable)
			mode = RMT_MODE_ALARM;
		else
			mode = backup_mode_i ? RMT_MODE_OFF : RMT_MODE_GP;
	end

	always_comb
	begin
		case (mode)
			RMT_MODE_SQW: pin_level_nxt = sqw_level;
			RMT_MODE_ALARM:
			begin
				if (alarm0_enable & alarm1_enable)
					pin_level_nxt = alarm_polarity_i ?
						(alarm0_flag_i | alarm1_flag_i) :
						~(alarm0_flag_i & alarm1_flag_i);
				else if (alarm0_enable)
					pin_level_nxt = ~(alarm0_flag_i ^ alarm_polarity_i);
				else
					pin_level_nxt = ~(alarm1_flag_i ^ alarm_polarity_i);
			end
			RMT_MODE_GP: pin_level_nxt = gp_level;
			default: pin_level_nxt = 1'b1;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			pin_level_r <= 1'b1;
		else
			pin_level_r <= pin_level_nxt;
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			trim_tick_o <= 1'b0;
		else
			trim_tick_o <= eff_tick;
	end

	// open drain: pull low for a low level, release for high
	assign multi_function_pin_o = 1'b0;
	assign multi_function_pin_oe_n_o = pin_level_r;

	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_remove_armed;
		trim_evt && !trim_direction && (trim_magnitude != 7'h00);
	endsequence

	sequence s_add_armed;
		trim_evt && trim_direction && (trim_magnitude != 7'h00);
	endsequence

	chk_pin_low_only: assert property (
		multi_function_pin_o == 1'b0)
		else $error("pin driven high");
	chk_backup_no_sqw: assert property (
		backup_mode_i && clock_out_enable |=> multi_function_pin_oe_n_o)
		else $error("square wave on backup supply");
	chk_single_alarm: assert property (
		!clock_out_enable && alarm0_enable && !alarm1_enable
		|=> multi_function_pin_oe_n_o ==
			($past(alarm_polarity_i) ? $past(alarm0_flag_i) :
			!$past(alarm0_flag_i)))
		else $error("single alarm level wrong");
	chk_dual_alarm: assert property (
		!clock_out_enable && alarm0_enable && alarm1_enable
		&& !alarm_polarity_i
		|=> multi_function_pin_oe_n_o ==
			!($past(alarm0_flag_i) && $past(alarm1_flag_i)))
		else $error("dual alarm level wrong");
	chk_alarm_backup: assert property (
		backup_mode_i && !clock_out_enable && alarm1_enable
		&& !alarm0_enable && alarm_polarity_i
		|=> multi_function_pin_oe_n_o == $past(alarm1_flag_i))
		else $error("alarm lost on backup");
	chk_gp_level: assert property (
		mode == RMT_MODE_GP |=> multi_function_pin_oe_n_o == $past(gp_level))
		else $error("gp level not followed");
	chk_gp_backup: assert property (
		backup_mode_i && !clock_out_enable && !alarm0_enable && !alarm1_enable
		|=> multi_function_pin_oe_n_o)
		else $error("gp level on backup");
	chk_sqw_bypass: assert property (
		mode == RMT_MODE_SQW && !coarse_trim_enable
		&& clock_rate_select == RMT_RATE_DIV1
		|=> multi_function_pin_oe_n_o == $past(osc_level_i))
		else $error("1:1 output not raw oscillator");
	chk_sqw_div8: assert property (
		mode == RMT_MODE_SQW && !coarse_trim_enable
		&& clock_rate_select == RMT_RATE_DIV8
		|=> multi_function_pin_oe_n_o == $past(presc_r[RMT_TAP_DIV8]))
		else $error("divide by 8 tap wrong");
	chk_trim_load: assert property (
		trim_evt |=> trim_pend_r == {$past(trim_magnitude), 1'b0}
		&& trim_add_r == $past(trim_direction))
		else $error("trim count not loaded");
	chk_trim_zero: assert property (
		trim_evt && trim_magnitude == 7'h00 |=> !add_act && !remove_act)
		else $error("zero trim still active");
	chk_remove_drop: assert property (
		s_remove_armed |=> (osc_tick |-> !eff_tick))
		else $error("removed pulse passed");
	chk_add_insert: assert property (
		s_add_armed ##1 !osc_tick |-> eff_tick)
		else $error("added pulse missing");
	chk_minute_rate: assert property (
		!coarse_trim_enable && sec_wrap && sec_cnt_r == RMT_SEC_LAST
		|-> trim_evt)
		else $error("minute trim missed");
	chk_coarse_rate: assert property (
		coarse_trim_enable && eff_tick && presc_r[7:0] != RMT_COARSE_LAST
		|-> !trim_evt)
		else $error("coarse trim off period");
	// each tap checked on its own so a swapped index shows up
	chk_sqw_div4: assert property (
		mode == RMT_MODE_SQW && !coarse_trim_enable
		&& clock_rate_select == RMT_RATE_DIV4
		|=> multi_function_pin_oe_n_o == $past(presc_r[RMT_TAP_DIV4]))
		else $error("divide by 4 tap wrong");
	chk_sqw_1hz: assert property (
		mode == RMT_MODE_SQW && !coarse_trim_enable
		&& clock_rate_select == RMT_RATE_1HZ
		|=> multi_function_pin_oe_n_o == $past(presc_r[RMT_TAP_1HZ]))
		else $error("1 Hz tap wrong");
	chk_coarse_tap: assert property (
		mode == RMT_MODE_SQW && coarse_trim_enable
		|=> multi_function_pin_oe_n_o == $past(presc_r[RMT_TAP_64HZ]))
		else $error("coarse 64 Hz tap wrong");
	chk_dual_or: assert property (
		!clock_out_enable && alarm0_enable && alarm1_enable
		&& alarm_polarity_i
		|=> multi_function_pin_oe_n_o ==
			($past(alarm0_flag_i) || $past(alarm1_flag_i)))
		else $error("dual alarm or level wrong");
	chk_single_alarm1: assert property (
		!clock_out_enable && alarm1_enable && !alarm0_enable
		|=> multi_function_pin_oe_n_o ==
			($past(alarm_polarity_i) ? $past(alarm1_flag_i) :
			!$past(alarm1_flag_i)))
		else $error("single alarm 1 level wrong");
	chk_sqw_wins: assert property (
		clock_out_enable && !backup_mode_i
		&& (alarm0_enable || alarm1_enable)
		|=> multi_function_pin_oe_n_o == $past(sqw_level))
		else $error("alarm took the pin from square wave");
	chk_trim_backup: assert property (
		backup_mode_i && osc_tick && !remove_act |-> eff_tick)
		else $error("tick lost on backup");
	// one pending unit per removed edge or per inserted tick
	chk_remove_step: assert property (
		remove_act && osc_tick && !trim_evt
		|=> trim_pend_r == $past(trim_pend_r) - 8'h01)
		else $error("removal count not stepped");
	chk_add_step: assert property (
		add_act && !osc_tick && !trim_evt
		|=> trim_pend_r == $past(trim_pend_r) - 8'h01)
		else $error("insertion count not stepped");
endmodule

// ### verif/rmt_pin_load.sv
`timescale 1ns/10ps
module rmt_pin_load (
	input wire logic pin_o_i,
	input wire logic pin_oe_n_i,
	output logic pin_level_o
);
	// no keeper on the line: a released pin is the pull-up level
	assign pin_level_o = pin_oe_n_i ? 1'b1 : pin_o_i;
endmodule

// ### verif/test_rmt_top.sv
`timescale 1ns/10ps
module test_rmt_top;
	import rmt_pkg::*;
	logic clock_i = 0, rst_n_i = 0, osc = 0, osc_run = 0, bk = 0, wr = 0;
	logic pol = 0, f0 = 0, f1 = 0, pin_o, oe_n, tick, pin;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
	int miscompares = 0, total_checks = 0;
	rmt_top rmt_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.osc_level_i(osc), .backup_mode_i(bk), .reg_wr_i(wr),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
		.alarm_polarity_i(pol), .alarm0_flag_i(f0), .alarm1_flag_i(f1),
		.multi_function_pin_o(pin_o), .multi_function_pin_oe_n_o(oe_n),
		.trim_tick_o(tick));
	rmt_pin_load rmt_pin_load_inst (.pin_o_i(pin_o), .pin_oe_n_i(oe_n),
		.pin_level_o(pin));
	initial
	begin
		forever #25 clock_i = ~clock_i;
	end
	// oscillator stands still unless a test lets it run
	always @(negedge clock_i) osc <= osc_run ? ~osc : 1'b0;
	task automatic wrap_up;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic do_reset;
		osc_run = 0;
		rst_n_i = 0;
		repeat (12) @(negedge clock_i);
		rst_n_i = 1;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock_i);
		wr = 1;
		addr = a;
		wdata = d;
		@(negedge clock_i);
		wr = 0;
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clock_i);
		addr = a;
		@(negedge clock_i);
		check("register", {8'h00, rdata}, {8'h00, exp});
	endtask
	task automatic pin_is(input logic exp);
		repeat (2) @(negedge clock_i);
		check("pin", {15'h0, pin}, {15'h0, exp});
	endtask
	// one full period of the pin, high and low halves counted apart
	task automatic meas(input logic [7:0] c, input int half);
		int k;
		wr_reg(RMT_CTRL_ADDR, c);
		osc_run <= 1'b1;
		k = 0;
		while (pin !== 1'b0 && k < 2000)
		begin
			@(negedge clock_i);
			k++;
		end
		while (pin !== 1'b1 && k < 4000)
		begin
			@(negedge clock_i);
			k++;
		end
		k = 0;
		while (pin === 1'b1 && k < 2000)
		begin
			@(negedge clock_i);
			k++;
		end
		check("high half", k[15:0], half[15:0]);
		k = 0;
		while (pin === 1'b0 && k < 2000)
		begin
			@(negedge clock_i);
			k++;
		end
		check("low half", k[15:0], half[15:0]);
	endtask
	// coarse mode, 1024 oscillator edges, count the trimmed ticks
	task automatic trim_run(input logic [7:0] t, input logic b, output int n);
		int e;
		logic prev;
		do_reset();
		bk = b;
		wr_reg(RMT_TRIM_ADDR, t);
		wr_reg(RMT_CTRL_ADDR, 8'h04);
		osc_run <= 1'b1;
		e = 0;
		n = 0;
		prev = 0;
		while (e < 1024)
		begin
			@(negedge clock_i);
			#1;
			if (osc && !prev)
				e++;
			prev = osc;
			if (tick === 1'b1)
				n++;
		end
		osc_run = 0;
		repeat (10)
		begin
			@(negedge clock_i);
			#1;
			if (tick === 1'b1)
				n++;
		end
		bk = 0;
	endtask
	initial
	begin
		#2ms;
		miscompares++;
		wrap_up();
	end
	initial
	begin
		int n;
		do_reset();
		rd_reg(RMT_CTRL_ADDR, RMT_CTRL_RST);
		rd_reg(RMT_TRIM_ADDR, RMT_TRIM_RST);
		wr_reg(8'h09, 8'hFF);
		rd_reg(8'h09, 8'h00);
		wr_reg(RMT_TRIM_ADDR, 8'hA5);
		rd_reg(RMT_TRIM_ADDR, 8'hA5);
		$display("registers done");
		pin_is(1'b1);
		wr_reg(RMT_CTRL_ADDR, 8'h00);
		pin_is(1'b0);
		bk = 1;
		pin_is(1'b1);
		bk = 0;
		// alarm would release, a stopped square wave holds the pin low
		wr_reg(RMT_CTRL_ADDR, 8'h70);
		pin_is(1'b0);
		bk = 1;
		pin_is(1'b1);
		$display("general purpose done");
		for (int en = 1; en < 4; en++)
		begin
			wr_reg(RMT_CTRL_ADDR, {2'b00, en[1:0], 4'h0});
			for (int v = 0; v < 8; v++)
			begin
				{pol, f1, f0} = v[2:0];
				if (en == 3)
					pin_is(pol ? (f0 | f1) : ~(f0 & f1));
				else
					pin_is(~pol ^ (en == 1 ? f0 : f1));
			end
		end
		{bk, pol, f1, f0} = 4'h0;
		$display("alarm done");
		// no trim here: the coarse tap then shows its plain half period
		wr_reg(RMT_TRIM_ADDR, 8'h00);
		meas(8'h43, 1);
		meas(8'h42, 4);
		meas(8'h41, 8);
		meas(8'h44, 512);
		$display("square wave done");
		trim_run(8'h02, 1'b0, n);
		check("ticks removed", n[15:0], 16'd1012);
		trim_run(8'h81, 1'b1, n);
		check("ticks added", n[15:0], 16'd1032);
		trim_run(8'h00, 1'b0, n);
		check("ticks untrimmed", n[15:0], 16'd1024);
		$display("trim done");
		wrap_up();
	end
endmodule
